// ---- hw/crfc_top.sv ----
// Purpose: Receive-side frame control of a contactless reader.
// Assumes: All inputs synchronous to i_mclk; decoder supplies bytes.
// Notes:   The FIFO module below buffers bytes toward the host.
// Notes on behaviour
// - Start frame seen and enabled raises interrupt.
// - Start frame seen flag sticks until cleared.
// - Subcarrier seen and enabled raises same interrupt.
// - Subcarrier seen flag sticks until cleared.
// - Subcarrier now bit shows live detection.
// - Partial byte store keeps incomplete final byte.
// - Continuous receive stays ready after frame end.
// - Continuous receive appends error byte per frame.
// - End frame kind selects symbol or Type B.
// - Kind zero, symbol bits zero: no check.
// - Type B guard time too long: protocol error.
// - Error in first three bytes flushes FIFO.
// - Suppressed disturbance raises no receive done.
// - Baud code 2h to 7h, rest reserved.
// - Blank unit: 16 carrier cycles or half bit.
// - After transmit, ignore input for blank time.
// - Upper threshold bits give minimum amplitude.
// - Lower threshold bits give phase level.
// - Half bit tick follows bit stream rate.
`timescale 1ns/100ps

// ******************************************************************
// Byte FIFO
// ******************************************************************
module crfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             i_mclk,
  input  wire logic             i_resetn,
  input  wire logic             i_flush,
  // Fill side.
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side.
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic [WIDTH-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];     // Storage array.
  logic [AW-1:0]    wp_reg;          // Write pointer.
  logic [AW-1:0]    rp_reg;          // Read pointer.
  logic [AW:0]      cnt_reg;         // Fill level.
  wire              push = i_valid && o_ready;
  wire              pop  = o_valid && i_ready;

  assign o_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_valid = (cnt_reg != '0);
  assign o_data  = mem[rp_reg];

  // Pointers wrap at the depth; a flush drops everything at once.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || i_flush) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset.
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wp_reg] <= i_data;
    end
  end
endmodule : crfc_fifo

// ******************************************************************
// Top
// ******************************************************************
module crfc_top
  import crfc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int EGT_MAX    = EGT_MAX_CYC
) (
  // Clock and reset.
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  // Register port.
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic [7:0]      o_reg_rdata,
  // Detector and decoder events.
  input  wire logic       i_sof_det,
  input  wire logic       i_subc_det,
  input  wire logic       i_tx_end,
  input  wire logic       i_half_bit_tick,
  input  wire logic       i_crc_en,
  input  wire logic [1:0] i_end_symbol_config,
  input  wire logic [7:0] i_error_reg,
  // Byte stream from the decoder.
  input  wire logic       i_rx_valid,
  input  wire crfc_byte_t i_rx_byte,
  output logic            o_rx_ready,
  // Byte stream to the host.
  output logic            o_fifo_valid,
  input  wire logic       i_fifo_ready,
  output logic [7:0]      o_fifo_data,
  // Status and decoder settings.
  output logic            o_start_frame_irq,
  output logic            o_rx_done_irq,
  output logic            o_proto_err,
  output logic            o_eof_check_en,
  output logic            o_eof_kind_b,
  output logic [2:0]      o_baud_code,
  output logic            o_baud_valid,
  output logic [3:0]      o_min_amplitude,
  output logic [3:0]      o_min_phase_level
);
  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [7:0]  sofd_reg;       // Enables and sticky flags.
  logic [7:0]  ctrl_reg;       // Frame control.
  logic [7:0]  blank_reg;      // Blank unit and count.
  logic [7:0]  level_reg;      // Decoder thresholds.
  logic [7:0]  rdata_reg;      // Read data.
  crfc_state_t state_reg;      // Receiver state.
  logic [6:0]  blank_cnt_reg;  // Units still to wait.
  logic [4:0]  unit_cnt_reg;   // Cycles within one unit.
  logic [1:0]  nbytes_reg;     // Bytes in frame, saturating at 3.
  logic        err_pend_reg;   // Error byte waiting for the FIFO.
  logic        done_reg;       // Receive done pulse.
  logic        perr_reg;       // Guard time protocol error.
  logic [15:0] egt_cnt_reg;    // Cycles since the last byte.
  logic        flush_reg;      // FIFO flush pulse.

  // ****************************************************************
  // Decoding
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a);
    hit = i_reg_wr && (i_reg_addr == a);
  endfunction : hit

  wire blanking  = (state_reg == CRFC_BLANK);
  wire sof_ev    = i_sof_det && !blanking;
  wire subc_ev   = i_subc_det && !blanking;
  wire wr_sofd   = hit(ADDR_SOF_DETECT);
  wire rx_take   = i_rx_valid && o_rx_ready;
  wire in_recv   = (state_reg == CRFC_RECV);
  wire early     = (nbytes_reg != DISTURB_BYTES);
  wire suppress  = ctrl_reg[B_DISTURB];
  // Disturbance: error early, or frame ends before three bytes.
  wire emd_hit   = rx_take && suppress &&
                   ((early && i_rx_byte.err) ||
                    (i_rx_byte.last && nbytes_reg < 2'h2));
  // An incomplete final byte is kept only when allowed.
  wire partial   = i_rx_byte.last && (i_rx_byte.bits != 3'h0);
  wire keep      = !(partial && i_crc_en && !ctrl_reg[B_PARTIAL]);
  wire frame_end = rx_take && i_rx_byte.last;
  wire fifo_rdy;
  wire fifo_in_v = (rx_take && keep && !emd_hit) || err_pend_reg;
  wire [7:0] fifo_in_d = err_pend_reg ? i_error_reg
                                      : i_rx_byte.data;
  wire unit_done = blank_reg[B_BLANK_UNIT] ? i_half_bit_tick
                 : (unit_cnt_reg == 5'(BLANK_UNIT_CYC - 1));
  wire egt_long  = ctrl_reg[B_EOF_KIND] && ctrl_reg[B_GUARD] &&
                   in_recv && (nbytes_reg != 2'h0) &&
                   (egt_cnt_reg == 16'(EGT_MAX));

  // Stall the decoder while the FIFO is full, the error byte waits, or
  // a flush is due: a byte taken then would be wiped with the debris.
  assign o_rx_ready = in_recv && fifo_rdy && !err_pend_reg && !flush_reg;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Sticky flags: write 0 clears, detection in the same cycle wins.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      sofd_reg <= RESET_ZERO;
    end else begin
      if (wr_sofd) begin
        sofd_reg[B_SOF_EN]  <= i_reg_wdata[B_SOF_EN];
        sofd_reg[B_SUBCARRIER_IRQ_ENABLE] <= i_reg_wdata[B_SUBCARRIER_IRQ_ENABLE];
      end
      sofd_reg[B_SOF_SEEN]  <= sof_ev ||
        (sofd_reg[B_SOF_SEEN] && !(wr_sofd && !i_reg_wdata[B_SOF_SEEN]));
      sofd_reg[B_SUBC_SEEN] <= subc_ev ||
        (sofd_reg[B_SUBC_SEEN] &&
         !(wr_sofd && !i_reg_wdata[B_SUBC_SEEN]));
      sofd_reg[B_SUBC_NOW]  <= i_subc_det;
    end
  end

  // Plain read/write configuration registers.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      ctrl_reg  <= RESET_ZERO;
      blank_reg <= RESET_ZERO;
      level_reg <= RESET_ZERO;
    end else begin
      if (hit(ADDR_RX_CTRL))    ctrl_reg  <= i_reg_wdata;
      if (hit(ADDR_BLANK_TIME)) blank_reg <= i_reg_wdata;
      if (hit(ADDR_MIN_LEVEL))  level_reg <= i_reg_wdata;
    end
  end

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rdata_reg <= RESET_ZERO;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_SOF_DETECT: rdata_reg <= sofd_reg & 8'h37;
        ADDR_RX_CTRL:    rdata_reg <= ctrl_reg;
        ADDR_BLANK_TIME: rdata_reg <= blank_reg;
        ADDR_MIN_LEVEL:  rdata_reg <= level_reg;
        default:         rdata_reg <= RESET_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // Receive sequencing
  // ****************************************************************
  // A transmit end always restarts blanking, even mid-frame.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state_reg     <= CRFC_IDLE;
      blank_cnt_reg <= 7'h00;
      unit_cnt_reg  <= 5'h00;
    end else if (i_tx_end) begin
      state_reg     <= CRFC_BLANK;
      blank_cnt_reg <= blank_reg[B_BLANK_HI:0];
      unit_cnt_reg  <= 5'h00;
    end else begin
      case (state_reg)
        CRFC_BLANK: begin
          if (blank_cnt_reg == 7'h00) begin
            state_reg <= CRFC_RECV;
          end else if (unit_done) begin
            blank_cnt_reg <= blank_cnt_reg - 7'h01;
            unit_cnt_reg  <= 5'h00;
          end else begin
            unit_cnt_reg  <= unit_cnt_reg + 5'h01;
          end
        end
        CRFC_RECV: begin
          if (frame_end && !emd_hit && !ctrl_reg[B_CONT]) begin
            state_reg <= CRFC_IDLE;
          end
        end
        default: state_reg <= CRFC_IDLE;
      endcase
    end
  end

  // Frame bookkeeping: byte count, error byte, done and flush pulses.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      nbytes_reg   <= 2'h0;
      err_pend_reg <= 1'b0;
      done_reg     <= 1'b0;
      flush_reg    <= 1'b0;
    end else begin
      done_reg  <= frame_end && !emd_hit;
      flush_reg <= emd_hit;
      if (frame_end || emd_hit || i_tx_end) begin
        nbytes_reg <= 2'h0;
      end else if (rx_take && early) begin
        nbytes_reg <= nbytes_reg + 2'h1;
      end
      if (frame_end && ctrl_reg[B_CONT] && !emd_hit) begin
        err_pend_reg <= 1'b1;
      end else if (fifo_rdy) begin
        err_pend_reg <= 1'b0;
      end
    end
  end

  // Guard time: cycles between bytes of a Type B frame.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      egt_cnt_reg <= 16'h0000;
      perr_reg    <= 1'b0;
    end else begin
      if (rx_take || !in_recv) begin
        egt_cnt_reg <= 16'h0000;
      end else if (!egt_long) begin
        egt_cnt_reg <= egt_cnt_reg + 16'h0001;
      end
      if (sof_ev) begin
        perr_reg <= 1'b0;
      end else if (egt_long) begin
        perr_reg <= 1'b1;
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_start_frame_irq <= 1'b0;
      o_eof_check_en    <= 1'b0;
      o_eof_kind_b      <= 1'b0;
      o_baud_code       <= 3'h0;
      o_baud_valid      <= 1'b0;
      o_min_amplitude   <= 4'h0;
      o_min_phase_level <= 4'h0;
    end else begin
      o_start_frame_irq <=
        (sofd_reg[B_SOF_EN]  && sofd_reg[B_SOF_SEEN]) ||
        (sofd_reg[B_SUBCARRIER_IRQ_ENABLE] && sofd_reg[B_SUBC_SEEN]);
      o_eof_kind_b      <= ctrl_reg[B_EOF_KIND];
      o_eof_check_en    <= ctrl_reg[B_EOF_KIND] ||
                           (i_end_symbol_config != 2'h0);
      o_baud_code       <= ctrl_reg[B_BAUD_HI:0];
      o_baud_valid      <= ctrl_reg[B_BAUD_HI:0] >= BAUD_MIN_CODE;
      o_min_amplitude   <= level_reg[7:4];
      o_min_phase_level <= level_reg[3:0];
    end
  end

  assign o_reg_rdata   = rdata_reg;
  assign o_rx_done_irq = done_reg;
  assign o_proto_err   = perr_reg;

  // Drain side blocks on the host, which empties the FIFO for real.
  crfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_mclk  (i_mclk),
    .i_resetn(i_resetn),
    .i_flush (flush_reg),
    .i_valid (fifo_in_v),
    .o_ready (fifo_rdy),
    .i_data  (fifo_in_d),
    .o_valid (o_fifo_valid),
    .i_ready (i_fifo_ready),
    .o_data  (o_fifo_data)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_sof_sticky;
    @(posedge i_mclk) disable iff (!i_resetn)
      sof_ev |=> sofd_reg[B_SOF_SEEN];
  endproperty
  a_sof_sticky: assert property (p_sof_sticky)
    else $error("Start frame flag not set.");
  property p_sof_irq;
    @(posedge i_mclk) disable iff (!i_resetn)
      sofd_reg[B_SOF_EN] && sofd_reg[B_SOF_SEEN] |=> o_start_frame_irq;
  endproperty
  a_sof_irq: assert property (p_sof_irq)
    else $error("Start frame interrupt missing.");
  property p_subc_irq;
    @(posedge i_mclk) disable iff (!i_resetn)
      subc_ev && sofd_reg[B_SUBCARRIER_IRQ_ENABLE] |-> ##2 o_start_frame_irq;
  endproperty
  a_subc_irq: assert property (p_subc_irq)
    else $error("Subcarrier interrupt missing.");
  property p_subc_now;
    @(posedge i_mclk) disable iff (!i_resetn)
      ##1 sofd_reg[B_SUBC_NOW] == $past(i_subc_det);
  endproperty
  a_subc_now: assert property (p_subc_now)
    else $error("Subcarrier now bit stale.");
  property p_blank_quiet;
    @(posedge i_mclk) disable iff (!i_resetn)
      blanking |-> !o_rx_ready ##1 (!$rose(sofd_reg[B_SOF_SEEN]) &&
        !$rose(sofd_reg[B_SUBC_SEEN]));
  endproperty
  a_blank_quiet: assert property (p_blank_quiet)
    else $error("Input taken during blanking.");
  property p_emd_no_done;
    @(posedge i_mclk) disable iff (!i_resetn)
      emd_hit |=> !o_rx_done_irq && flush_reg;
  endproperty
  a_emd_no_done: assert property (p_emd_no_done)
    else $error("Disturbance raised receive done.");
  property p_err_byte;
    @(posedge i_mclk) disable iff (!i_resetn)
      frame_end && ctrl_reg[B_CONT] && !emd_hit |=> err_pend_reg
        ##[0:40] (fifo_in_v && fifo_rdy);
  endproperty
  a_err_byte: assert property (p_err_byte)
    else $error("Error byte not appended.");
  property p_cont;
    @(posedge i_mclk) disable iff (!i_resetn)
      frame_end && !emd_hit && !i_tx_end |=>
        (state_reg == CRFC_RECV) == $past(ctrl_reg[B_CONT]);
  endproperty
  a_cont: assert property (p_cont)
    else $error("Wrong state after frame end.");
endmodule : crfc_top

// ---- include/crfc_pkg.sv ----
// Purpose: Constants and types for the receive frame control block.
// Assumes: System clock of 25 MHz.
// Notes:   Register offsets are byte addresses on the register port.
package crfc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_SOF_DETECT  = 8'h34; // Start of frame.
  localparam logic [7:0] ADDR_RX_CTRL     = 8'h35; // Frame control.
  localparam logic [7:0] ADDR_BLANK_TIME  = 8'h36; // Blank time.
  localparam logic [7:0] ADDR_MIN_LEVEL   = 8'h37; // Decoder levels.
  localparam logic [7:0] RESET_ZERO       = 8'h00; // Reset of all regs.
  // Field positions in start_of_frame_detect.
  localparam int B_SOF_EN    = 5;
  localparam int B_SOF_SEEN  = 4;
  localparam int B_SUBCARRIER_IRQ_ENABLE   = 2;
  localparam int B_SUBC_SEEN = 1;
  localparam int B_SUBC_NOW  = 0;
  // Field positions in receive_frame_control.
  localparam int B_PARTIAL   = 7;
  localparam int B_CONT      = 6;
  localparam int B_EOF_KIND  = 5;
  localparam int B_GUARD     = 4;
  localparam int B_DISTURB   = 3;
  localparam int B_BAUD_HI   = 2;
  // Field positions in receive_blank_time.
  localparam int B_BLANK_UNIT = 7;
  localparam int B_BLANK_HI   = 6;
  // Baud codes.
  localparam logic [2:0] BAUD_MIN_CODE = 3'h2; // 26 kBd; 7h is 847.
  // Disturbance window in bytes.
  localparam logic [1:0] DISTURB_BYTES = 2'h3;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ        = 25000;  // System clock.
  localparam int CARRIER_KHZ    = 13560;  // Carrier frequency.
  localparam int CARRIER_CYCLES = 16;     // Carrier cycles per unit.
  // Least time, so round up.
  localparam int BLANK_UNIT_CYC =
    (CARRIER_CYCLES * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;
  localparam int EGT_MAX_CYC    = 200;    // Guard time limit, plain.
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    CRFC_IDLE  = 2'b00,
    CRFC_BLANK = 2'b01,
    CRFC_RECV  = 2'b11
  } crfc_state_t;
  // One byte from the bit decoder.
  typedef struct packed {
    logic [7:0] data;  // Received byte.
    logic [2:0] bits;  // Valid bits of a partial byte, 0 for full.
    logic       last;  // Last byte of the frame.
    logic       err;   // Error or collision seen in this byte.
  } crfc_byte_t;
endpackage : crfc_pkg

// ---- sim/contactless_receive_frame_control_tb.sv ----
// Purpose: Self-checking bench for the receive frame control block.
// Assumes: Register strobes and stimulus change at the falling edge.
// Notes:   A host stall in Type B reception trips the guard time.
`timescale 1ns/100ps
module contactless_receive_frame_control_tb
  import crfc_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic       i_mclk = 1'b0, i_resetn = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, err_reg = 8'h00;
  logic       wr = 1'b0, rd = 1'b0, tx_end = 1'b0, crc_en = 1'b0;
  logic       fifo_ready = 1'b0, rx_valid, rx_ready, sof, subc;
  logic [1:0] esc = 2'h0;
  crfc_byte_t rx_byte;
  logic       fv, irq, done, perr, eof_en, kind_b, baud_ok;
  logic [7:0] fdata, v, b;
  logic [2:0] baud;
  logic [3:0] amp, ph;
  logic [7:0] q[$];
  logic       hbt = 1'b0;
  int         stalls;
  int         n_errors = 0, total_checks = 0, n_done = 0, done_exp = 0;

  always #20 i_mclk = ~i_mclk;
  // Receive-done pulses last one cycle, so each edge counts once.
  always @(posedge i_mclk) if (done === 1'b1) n_done++;

  crfc_top #(.FIFO_DEPTH(16), .EGT_MAX(10)) u_crfc_top (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_sof_det(sof), .i_subc_det(subc),
    .i_tx_end(tx_end), .i_half_bit_tick(hbt), .i_crc_en(crc_en),
    .i_end_symbol_config(esc), .i_error_reg(err_reg),
    .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .o_rx_ready(rx_ready),
    .o_fifo_valid(fv), .i_fifo_ready(fifo_ready), .o_fifo_data(fdata),
    .o_start_frame_irq(irq), .o_rx_done_irq(done), .o_proto_err(perr),
    .o_eof_check_en(eof_en), .o_eof_kind_b(kind_b), .o_baud_code(baud),
    .o_baud_valid(baud_ok), .o_min_amplitude(amp),
    .o_min_phase_level(ph));

  crfc_card_model u_crfc_card_model (
    .i_mclk(i_mclk), .o_sof_det(sof), .o_subc_det(subc),
    .o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .i_rx_ready(rx_ready),
    .o_stalls(stalls));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic wreg(input logic [7:0] a, d);
    @(negedge i_mclk);
    addr = a; wdata = d; wr = 1'b1;
    @(negedge i_mclk);
    wr = 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    addr = a; rd = 1'b1;
    @(negedge i_mclk);
    rd = 1'b0; d = rdata;
  endtask : rreg

  // Transmit end; the receiver blanks and then listens.
  task automatic txe();
    @(negedge i_mclk);
    tx_end = 1'b1;
    @(negedge i_mclk);
    tx_end = 1'b0;
  endtask : txe

  // Pops every expected byte, then the FIFO must be empty.
  task automatic drain();
    int w;
    foreach (q[i]) begin
      w = 0;
      while (fv !== 1'b1 && w < 500) begin
        fifo_ready = 1'b0;
        @(negedge i_mclk);
        w++;
      end
      if (w >= 500) begin
        n_errors++;
        finish_test();
      end
      check("fifo data", fdata, q[i]);
      fifo_ready = 1'b1;
      @(negedge i_mclk);
    end
    fifo_ready = 1'b0;
    check("fifo empty", {7'h0, fv}, 8'h00);
    q.delete();
  endtask : drain

  function automatic logic [7:0] bt(input logic [7:0] base, input int i);
    return base + 8'(i);
  endfunction : bt

  task automatic frame_q(input logic [7:0] base, input int lo, hi);
    for (int i = lo; i < hi; i++) q.push_back(bt(base, i));
  endtask : frame_q

  task automatic end_test(input string nm);
    check("done count", 8'(n_done), 8'(done_exp));
    check("card stalls", 8'(stalls), 8'h00);
    $display("Test %s finished", nm);
  endtask : end_test

  initial begin
    repeat (100000) @(posedge i_mclk);
    n_errors++;
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    v = 8'($urandom(32'hbb4b));
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk) i_resetn = 1'b1;
    for (int a = 8'h34; a <= 8'h38; a++) begin
      rreg(8'(a), v);
      check("reset value", v, RESET_ZERO);
    end
    end_test("reset");
    // Every baud code and end frame setting.
    for (int c = 0; c < 8; c++) begin
      // Code 0 gives no end check at all; code 4 is always Type B.
      b = {2'h0, 1'(c == 4 || (c != 0 && $urandom() % 2)), 2'h0, 3'(c)};
      esc = 2'(c);
      wreg(ADDR_RX_CTRL, b);
      rreg(ADDR_RX_CTRL, v);
      check("ctrl readback", v, b);
      check("baud code", {5'h0, baud}, b[2:0]);
      check("baud valid", {7'h0, baud_ok}, 8'(c >= 2));
      check("kind", {7'h0, kind_b}, {7'h0, b[5]});
      check("eof check", {7'h0, eof_en}, 8'(b[5] | |esc));
    end
    b = 8'($urandom());
    wreg(ADDR_MIN_LEVEL, b);
    rreg(ADDR_MIN_LEVEL, v);
    check("level readback", v, b);
    check("amplitude", {4'h0, amp}, {4'h0, b[7:4]});
    check("phase level", {4'h0, ph}, {4'h0, b[3:0]});
    end_test("settings");
    // Sticky flags and the shared start interrupt.
    wreg(ADDR_SOF_DETECT, 8'hE4 & ~8'h04);
    u_crfc_card_model.send(0, -1, 3'h0, 8'h00);
    rreg(ADDR_SOF_DETECT, v);
    check("flags", v, 8'h32);
    check("sof irq", {7'h0, irq}, 8'h01);
    wreg(ADDR_SOF_DETECT, 8'h20);
    rreg(ADDR_SOF_DETECT, v);
    check("cleared", v, 8'h20);
    check("irq low", {7'h0, irq}, 8'h00);
    wreg(ADDR_SOF_DETECT, 8'h04);
    u_crfc_card_model.send(0, -1, 3'h0, 8'h00);
    u_crfc_card_model.subc(1'b1);
    rreg(ADDR_SOF_DETECT, v);
    check("subc flags", v, 8'h17);
    check("subc irq", {7'h0, irq}, 8'h01);
    u_crfc_card_model.subc(1'b0);
    rreg(ADDR_SOF_DETECT, v);
    check("subc gone", v, 8'h16);
    end_test("flags");
    // Detection is masked during the blank time.
    wreg(ADDR_BLANK_TIME, 8'h05);
    wreg(ADDR_SOF_DETECT, 8'h20);
    txe();
    u_crfc_card_model.send(0, -1, 3'h0, 8'h00);
    rreg(ADDR_SOF_DETECT, v);
    check("blanked", v, 8'h20);
    // Half-bit unit: without ticks the blank time never runs out.
    wreg(ADDR_BLANK_TIME, 8'h81);
    txe();
    repeat (60) @(negedge i_mclk);
    u_crfc_card_model.send(0, -1, 3'h0, 8'h00);
    rreg(ADDR_SOF_DETECT, v);
    check("half bit wait", v, 8'h20);
    @(negedge i_mclk) hbt = 1'b1;
    @(negedge i_mclk) hbt = 1'b0;
    u_crfc_card_model.send(0, -1, 3'h0, 8'h00);
    rreg(ADDR_SOF_DETECT, v);
    check("half bit end", v, 8'h32);
    wreg(ADDR_BLANK_TIME, 8'h00);
    repeat (200) @(negedge i_mclk);
    end_test("blank");
    // Fill past the FIFO depth with the host stalled; in Type B with
    // the guard check on, the stall also trips the guard time.
    wreg(ADDR_RX_CTRL, 8'h30);
    txe();
    b = 8'($urandom());
    frame_q(b, 0, 18);
    done_exp++;
    fork
      u_crfc_card_model.send(18, -1, 3'h0, b);
      begin
        repeat (60) @(negedge i_mclk);
        check("full stall", {7'h0, rx_ready}, 8'h00);
        check("guard error", {7'h0, perr}, 8'h01);
        drain();
      end
    join
    end_test("fill");
    // Continuous receive: two frames, each with an error byte.
    err_reg = 8'($urandom());
    wreg(ADDR_RX_CTRL, 8'h70);
    txe();
    u_crfc_card_model.send(3, -1, 3'h0, b);
    u_crfc_card_model.send(2, -1, 3'h0, ~b);
    frame_q(b, 0, 3);
    q.push_back(err_reg);
    frame_q(~b, 0, 2);
    q.push_back(err_reg);
    done_exp += 2;
    drain();
    check("no guard error", {7'h0, perr}, 8'h00);
    end_test("continuous");
    // Partial final byte with the check enabled.
    crc_en = 1'b1;
    for (int p = 0; p < 2; p++) begin
      wreg(ADDR_RX_CTRL, p ? 8'h80 : 8'h00);
      txe();
      u_crfc_card_model.send(2, -1, 3'h3, b);
      frame_q(b, 0, 1 + p);
      done_exp++;
      repeat (4) @(negedge i_mclk);
      drain();
    end
    crc_en = 1'b0;
    end_test("partial");
    // Disturbance: an early error flushes; a short rest leaves nothing, a longer rest is kept.
    wreg(ADDR_RX_CTRL, 8'h08);
    txe();
    u_crfc_card_model.send(4, 1, 3'h0, b);
    repeat (4) @(negedge i_mclk);
    drain();
    end_test("short frame");
    u_crfc_card_model.send(5, 1, 3'h0, b);
    frame_q(b, 2, 5);
    done_exp++;
    repeat (4) @(negedge i_mclk);
    drain();
    end_test("disturbance");
    finish_test();
  end
endmodule : contactless_receive_frame_control_tb

// ---- sim/crfc_card_model.sv ----
// Purpose: Behavioural card that answers the reader over the field.
// Assumes: Bytes are taken at a rising edge with valid and ready high.
// Notes:   Idle byte lines show the inverse of the last byte sent.
`timescale 1ns/100ps
module crfc_card_model
  import crfc_pkg::*;
(
  // Clock.
  input  wire logic       i_mclk,
  // Detection and byte stream.
  output logic            o_sof_det,
  output logic            o_subc_det,
  output logic            o_rx_valid,
  output crfc_byte_t      o_rx_byte,
  input  wire logic       i_rx_ready,
  // Bytes that the reader never took.
  output int              o_stalls
);
  // Quiet field at time zero.
  initial begin
    o_sof_det  = 1'b0;
    o_subc_det = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_byte  = '0;
    o_stalls   = 0;
  end

  // Holds the subcarrier level from the next falling edge on.
  task automatic subc(input logic v);
    @(negedge i_mclk);
    o_subc_det = v;
  endtask : subc

  // One frame: start pulse, then n bytes from base, byte e in error.
  task automatic send(input int n, input int e, input logic [2:0] lb,
                      input logic [7:0] base);
    int w;
    @(negedge i_mclk);
    o_sof_det  = 1'b1;
    o_subc_det = 1'b1;
    @(negedge i_mclk);
    o_sof_det  = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_rx_valid     = 1'b1;
      o_rx_byte.data = base + 8'(i);
      o_rx_byte.last = (i == n - 1);
      o_rx_byte.bits = (i == n - 1) ? lb : 3'h0;
      o_rx_byte.err  = (i == e);
      w = 0;
      #1;
      // Hold the byte until the reader is ready at an edge.
      while (i_rx_ready !== 1'b1 && w < 4000) begin
        @(negedge i_mclk);
        #1;
        w++;
      end
      if (w >= 4000) o_stalls++;
      @(negedge i_mclk);
    end
    // Released lines do not keep the last value.
    o_rx_valid = 1'b0;
    o_rx_byte  = ~o_rx_byte;
    o_subc_det = 1'b0;
  endtask : send
endmodule : crfc_card_model
